//--- src/sirs_pkg.sv
/*
  Shared constants and types for the strapped two-wire register target.
  Assumes a register file outside that answers reads combinationally.
*/
// Contract
// [R1] Respond to a 7-bit target address in upper bits of first byte.
// [R2] Address byte bit 0 chooses direction: 0 write, 1 read.
// [R3] Top three address bits are always 100.
// [R4] Strap at ground gives 00, strap at supply gives 11.
// [R5] Strap on clock line gives 01, strap on data line gives 10.
// [R6] First strap sets bits 2:1, second strap sets bits 4:3.
// [R7] Host keeps the serial clock at or below 1MHz.
// [R8] Data line is sampled while the clock line is high.
// [R9] Host holds every bit stable while the clock is high.
// [R10] Data falling with clock high is a start; address compare begins.
// [R11] Host sends the address byte MSB first right after start.
// [R12] On address match the target pulls data low for the acknowledge.
// [R13] Host stops and abandons on a missing acknowledge.
// [R14] Register-address byte follows, MSB first, and is acknowledged.
// [R15] Each data byte MSB first is received and acknowledged.
// [R16] Data rising with clock high is a stop; it ends the transfer.
// [R17] Pointer steps by one at each received data byte acknowledge.
// [R18] Host reads by write, register address, repeated start, read address.
// [R19] After read address the target sends the selected register.
// [R20] Every register returns its contents when read.
// [R21] Data line rests released high between transfers.
// [R22] Clock is input only; data is driven open-drain only.
// [R23] On address mismatch stay released and ignore until next start.
// [R24] In reads, step pointer on host acknowledge; release on no acknowledge.
package sirs_pkg;
  // ------------------------------------------------------------
  // Address and bus constants
  // ------------------------------------------------------------
  localparam logic [2:0] FIXED_ADDRESS_PREFIX = 3'h4;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_VCC = 2'h3;
  localparam int STRAP_PINS = 2;
  localparam int SCL_MAX_KHZ = 1000;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SIRS_IDLE, SIRS_ADDR, SIRS_ACK_A, SIRS_REG, SIRS_ACK_W, SIRS_WDATA,
    SIRS_RLOAD, SIRS_RDATA, SIRS_RACK, SIRS_RHOLD, SIRS_IGNORE
  } sirs_state_e;

  typedef struct packed {
    logic write;
    logic [7:0] ptr;
    logic [7:0] data;
  } sirs_xfer_s;
endpackage

//--- src/sirs_strap.sv
/*
  Four-level strap decoder for one pin, on the link clock.
  Assumes strap, clock and data levels reach it through equal synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module sirs_strap (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic strap_i,
  input wire logic scl_s_i,
  input wire logic sda_s_i,
  output logic [1:0] bits_o
);
  logic strap_m_q;
  logic strap_s_q;
  logic seen_hi_q;
  logic seen_lo_q;
  logic diff_scl_q;
  logic diff_sda_q;

  // Two-flop synchroniser for the strap pin
  always_ff @(posedge clk_i) begin
    strap_m_q <= strap_i;
    strap_s_q <= strap_m_q;
  end

  // Watch which bus line, if any, the strap follows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_hi_q <= 1'b0;
      seen_lo_q <= 1'b0;
      diff_scl_q <= 1'b0;
      diff_sda_q <= 1'b0;
    end else begin
      if (strap_s_q) seen_hi_q <= 1'b1;
      if (!strap_s_q) seen_lo_q <= 1'b1;
      if (strap_s_q != scl_s_i) diff_scl_q <= 1'b1;
      if (strap_s_q != sda_s_i) diff_sda_q <= 1'b1; // Only read by the check below
    end
  end

  // Constant low, constant high, follows clock, else follows data
  always_comb begin
    if (!seen_hi_q) bits_o = sirs_pkg::STRAP_GND; // [R4]
    else if (!seen_lo_q) bits_o = sirs_pkg::STRAP_VCC; // [R4]
    else if (!diff_scl_q) bits_o = sirs_pkg::STRAP_SCL; // [R5]
    else bits_o = sirs_pkg::STRAP_SDA; // [R5]
  end

  // A strap decoded as data line must never have disagreed with it
  sda_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    bits_o == sirs_pkg::STRAP_SDA |-> !diff_sda_q)
    else $error("strap decoded as 10 but does not follow data");
endmodule
`default_nettype wire

//--- src/sirs_top.sv
/*
  Two-wire register target: protocol engine on the link clock, register
  file port on the system clock, word handshake between them.
  Assumes the register file answers reg_rdata_i combinationally from
  reg_ptr_o and that the link clock oversamples SCL well above 1MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module sirs_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic i2c_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic strap_pin_low_pair_i,
  input wire logic strap_pin_high_pair_i,
  output logic [7:0] reg_ptr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  input wire logic [7:0] reg_rdata_i
);
  // ------------------------------------------------------------
  // Link-domain reset and pin synchronisers
  // ------------------------------------------------------------
  logic lrst_m_q;
  logic link_rst;
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  // Reset carried into the link domain
  always_ff @(posedge i2c_clk_i) begin
    lrst_m_q <= rst_i;
    link_rst <= lrst_m_q;
  end

  // Clock line is input only, two flops then history
  always_ff @(posedge i2c_clk_i) begin
    scl_m_q <= scl_i; // [R22]
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Edge and bus condition decode
  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // [R10]
  assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q; // [R16]

  // ------------------------------------------------------------
  // Own address from straps
  // ------------------------------------------------------------
  logic [1:0] strap_bits [sirs_pkg::STRAP_PINS];
  logic [sirs_pkg::STRAP_PINS-1:0] strap_pins;
  logic [1:0] strap_bits_low;
  logic [1:0] strap_bits_high;
  logic [6:0] own_addr;

  assign strap_pins = {strap_pin_high_pair_i, strap_pin_low_pair_i};

  // One decoder per strap pin
  genvar gi;
  generate
    for (gi = 0; gi < sirs_pkg::STRAP_PINS; gi++) begin : g_strap
      sirs_strap u_strap (
        .clk_i(i2c_clk_i),
        .rst_i(link_rst),
        .strap_i(strap_pins[gi]),
        .scl_s_i(scl_s_q),
        .sda_s_i(sda_s_q),
        .bits_o(strap_bits[gi])
      );
    end
  endgenerate

  // Prefix fixed, low strap bits 2:1, high strap bits 4:3
  assign strap_bits_low = strap_bits[0]; // [R6]
  assign strap_bits_high = strap_bits[1]; // [R6]
  assign own_addr = {sirs_pkg::FIXED_ADDRESS_PREFIX, strap_bits_high, strap_bits_low}; // [R3]

  // ------------------------------------------------------------
  // Protocol engine
  // ------------------------------------------------------------
  sirs_pkg::sirs_state_e state_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic got_q;
  logic oe_q;
  logic direction_bit;
  logic [7:0] ptr_q;
  logic pend_q;
  logic [7:0] rd_data_q;
  logic addr_match;
  logic ev_reg;
  logic ev_wr;
  logic ev_inc_r;
  logic ev_rd;

  // Byte complete decode per state
  assign addr_match = (sh_q[7:1] == own_addr); // [R1]
  assign ev_reg = (state_q == sirs_pkg::SIRS_REG) && scl_fall && got_q && !start_det
    && !stop_det; // [R14]
  assign ev_wr = (state_q == sirs_pkg::SIRS_WDATA) && scl_fall && got_q && !start_det
    && !stop_det; // [R15]
  assign ev_inc_r = (state_q == sirs_pkg::SIRS_RACK) && scl_rise && !sda_s_q; // [R24]
  assign ev_rd = ((state_q == sirs_pkg::SIRS_ACK_A) && scl_fall && direction_bit
    && !start_det && !stop_det) || ev_inc_r; // [R19]

  // Main sequence, shift register and acknowledge drive
  always_ff @(posedge i2c_clk_i) begin
    if (link_rst) begin
      state_q <= sirs_pkg::SIRS_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      oe_q <= 1'b0;
      direction_bit <= 1'b0;
    end else if (start_det) begin
      state_q <= sirs_pkg::SIRS_ADDR; // [R10]
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= sirs_pkg::SIRS_IDLE; // [R16]
      got_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        sirs_pkg::SIRS_IDLE, sirs_pkg::SIRS_IGNORE: begin
          oe_q <= 1'b0; // [R23]
        end
        sirs_pkg::SIRS_ADDR, sirs_pkg::SIRS_REG, sirs_pkg::SIRS_WDATA: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q}; // [R8] [R11]
            cnt_q <= cnt_q + 3'h1;
            got_q <= (cnt_q == sirs_pkg::LAST_BIT);
          end else if (scl_fall && got_q) begin
            got_q <= 1'b0;
            cnt_q <= 3'h0;
            if (state_q == sirs_pkg::SIRS_ADDR) begin
              if (addr_match) begin
                oe_q <= 1'b1; // [R12]
                direction_bit <= sh_q[0]; // [R2]
                state_q <= sirs_pkg::SIRS_ACK_A;
              end else begin
                state_q <= sirs_pkg::SIRS_IGNORE; // [R23]
              end
            end else begin
              oe_q <= 1'b1; // [R14] [R15]
              state_q <= sirs_pkg::SIRS_ACK_W;
            end
          end
        end
        sirs_pkg::SIRS_ACK_A: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            state_q <= direction_bit ? sirs_pkg::SIRS_RLOAD : sirs_pkg::SIRS_REG; // [R2]
          end
        end
        sirs_pkg::SIRS_ACK_W: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            state_q <= sirs_pkg::SIRS_WDATA;
          end
        end
        sirs_pkg::SIRS_RLOAD: begin
          if (!pend_q) begin
            sh_q <= rd_data_q; // [R19] [R20]
            oe_q <= !rd_data_q[7];
            cnt_q <= 3'h0;
            state_q <= sirs_pkg::SIRS_RDATA;
          end
        end
        sirs_pkg::SIRS_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == sirs_pkg::LAST_BIT) begin
              oe_q <= 1'b0;
              state_q <= sirs_pkg::SIRS_RACK;
            end else begin
              oe_q <= !sh_q[6]; // [R22]
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 3'h1;
            end
          end
        end
        sirs_pkg::SIRS_RACK: begin
          if (scl_rise) begin
            state_q <= sda_s_q ? sirs_pkg::SIRS_IGNORE : sirs_pkg::SIRS_RHOLD; // [R24]
          end
        end
        sirs_pkg::SIRS_RHOLD: begin
          if (scl_fall) state_q <= sirs_pkg::SIRS_RLOAD;
        end
        default: state_q <= sirs_pkg::SIRS_IDLE; // Unused codes recover to idle
      endcase
    end
  end

  // Register pointer
  always_ff @(posedge i2c_clk_i) begin
    if (link_rst) begin
      ptr_q <= sirs_pkg::PTR_RESET;
    end else if (ev_reg) begin
      ptr_q <= sh_q;
    end else if (ev_wr || ev_inc_r) begin
      ptr_q <= ptr_q + 8'h01; // [R17] [R24]
    end
  end

  // Open-drain output: low level only, enable carries the bit
  always_ff @(posedge i2c_clk_i) begin
    if (link_rst) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0; // [R22]
      sda_oe_o <= oe_q;
    end
  end

  // ------------------------------------------------------------
  // Crossing to the register file
  // ------------------------------------------------------------
  sirs_pkg::sirs_xfer_s xfer_q;
  logic req_t_q;
  logic ack_m_q;
  logic ack_s_q;
  logic ack_p_q;
  logic ack_t_q;
  logic [7:0] rdata_hold_q;

  // Request word held stable until the next byte event
  always_ff @(posedge i2c_clk_i) begin
    if (link_rst) begin
      xfer_q <= '0;
      req_t_q <= 1'b0;
      pend_q <= 1'b0;
      rd_data_q <= 8'h00;
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      ack_p_q <= 1'b0;
    end else begin
      ack_m_q <= ack_t_q;
      ack_s_q <= ack_m_q;
      ack_p_q <= ack_s_q;
      if (ev_wr) begin
        xfer_q <= '{write: 1'b1, ptr: ptr_q, data: sh_q}; // [R15]
        req_t_q <= !req_t_q;
        pend_q <= 1'b1;
      end else if (ev_rd) begin
        xfer_q <= '{write: 1'b0, ptr: ev_inc_r ? ptr_q + 8'h01 : ptr_q, data: 8'h00};
        req_t_q <= !req_t_q;
        pend_q <= 1'b1;
      end else if (ack_s_q != ack_p_q) begin
        pend_q <= 1'b0;
        rd_data_q <= rdata_hold_q;
      end
    end
  end

  logic rq_m_q;
  logic rq_s_q;
  logic rq_p_q;
  logic rd_phase_q;
  logic rq_edge;

  assign rq_edge = rq_s_q ^ rq_p_q;

  // System side: capture request, strobe write, fetch read data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rq_m_q <= 1'b0;
      rq_s_q <= 1'b0;
      rq_p_q <= 1'b0;
      reg_ptr_o <= sirs_pkg::PTR_RESET;
      reg_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      rd_phase_q <= 1'b0;
      rdata_hold_q <= 8'h00;
      ack_t_q <= 1'b0;
    end else begin
      rq_m_q <= req_t_q;
      rq_s_q <= rq_m_q;
      rq_p_q <= rq_s_q;
      reg_wr_o <= rq_edge && xfer_q.write; // [R17]
      rd_phase_q <= rq_edge;
      if (rq_edge) begin
        reg_ptr_o <= xfer_q.ptr;
        reg_wdata_o <= xfer_q.data;
      end
      if (rd_phase_q) begin
        rdata_hold_q <= reg_rdata_i; // [R20]
        ack_t_q <= !ack_t_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  addr_prefix_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R3]
    state_q == sirs_pkg::SIRS_ACK_A |-> sh_q[7:5] == sirs_pkg::FIXED_ADDRESS_PREFIX)
    else $error("acknowledged address prefix is not 100");
  match_ack_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R12]
    (state_q == sirs_pkg::SIRS_ADDR && scl_fall && got_q && addr_match && !start_det
     && !stop_det) |=> ##1 sda_oe_o)
    else $error("no acknowledge after matching address");
  mismatch_quiet_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R23]
    (state_q == sirs_pkg::SIRS_ADDR && scl_fall && got_q && !addr_match && !start_det
     && !stop_det) |=> (state_q == sirs_pkg::SIRS_IGNORE && !oe_q))
    else $error("mismatched address not ignored");
  start_addr_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R10]
    start_det |=> state_q == sirs_pkg::SIRS_ADDR && cnt_q == 3'h0)
    else $error("start did not begin address compare");
  stop_idle_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R16]
    stop_det |=> state_q == sirs_pkg::SIRS_IDLE ##1 !sda_oe_o)
    else $error("stop did not end transfer");
  wr_step_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R17]
    ev_wr |=> ptr_q == 8'($past(ptr_q) + 8'h01) && xfer_q.ptr == $past(ptr_q))
    else $error("write pointer did not step");
  rd_step_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R24]
    ev_inc_r |=> ptr_q == 8'($past(ptr_q) + 8'h01) && pend_q)
    else $error("read pointer did not step on host acknowledge");
  nack_release_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R24]
    (state_q == sirs_pkg::SIRS_RACK && scl_rise && sda_s_q && !start_det && !stop_det)
    |=> state_q == sirs_pkg::SIRS_IGNORE [*2])
    else $error("no acknowledge did not release");
  drive_only_ack_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R22]
    oe_q |-> state_q inside {sirs_pkg::SIRS_ACK_A, sirs_pkg::SIRS_ACK_W,
    sirs_pkg::SIRS_RDATA})
    else $error("data driven outside acknowledge or read");
  dir_read_a: assert property (@(posedge i2c_clk_i) disable iff (link_rst) // [R2]
    (state_q == sirs_pkg::SIRS_ACK_A && scl_fall && direction_bit && !start_det
     && !stop_det) |=> state_q == sirs_pkg::SIRS_RLOAD)
    else $error("read direction not honoured");
  wr_strobe_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R15]
    (rq_edge && xfer_q.write) |=> reg_wr_o && reg_ptr_o == $past(xfer_q.ptr)
    && reg_wdata_o == $past(xfer_q.data))
    else $error("write strobe or data wrong");

  write_seen_c: cover property (@(posedge i2c_clk_i) disable iff (link_rst) ev_wr);
  read_load_c: cover property (@(posedge i2c_clk_i) disable iff (link_rst)
    state_q == sirs_pkg::SIRS_RLOAD ##1 state_q == sirs_pkg::SIRS_RDATA);
  read_burst_c: cover property (@(posedge i2c_clk_i) disable iff (link_rst) ev_inc_r);
  mismatch_c: cover property (@(posedge i2c_clk_i) disable iff (link_rst)
    state_q == sirs_pkg::SIRS_ADDR ##1 state_q == sirs_pkg::SIRS_IGNORE);
endmodule
`default_nettype wire

//--- test/sirs_host.sv
/*
  Bus controller model that drives the two-wire target from the bench.
  Assumes the bench resolves the data wire with a pull-up into sda_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sirs_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  // One step of 25 system cycles; five steps a bit, 400kHz
  localparam int STEP = 25;

  // Both lines released while idle
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Wait one step, moving only on falling system clock edges
  task automatic q;
    repeat (STEP) @(negedge clk_i);
  endtask

  // Data falls with clock high; also used as repeated start
  task automatic start;
    q;
    sda_low_o = 1'b0;
    q;
    scl_o = 1'b1;
    q;
    sda_low_o = 1'b1;
    q;
    scl_o = 1'b0;
  endtask

  // Data rises with clock high, leaving both lines released
  task automatic stop;
    q;
    sda_low_o = 1'b1;
    q;
    scl_o = 1'b1;
    q;
    sda_low_o = 1'b0;
    q;
  endtask

  // One pulse: data set in the long low phase, held over the high phase
  task automatic bit_io(input logic b, output logic r);
    q;
    sda_low_o = ~b;
    q;
    q;
    scl_o = 1'b1;
    q;
    r = sda_i;
    q;
    scl_o = 1'b0;
  endtask

  // Byte out most significant bit first, then a released acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in most significant bit first, then our acknowledge or release
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
/*
  Self-checking bench: host model on the bus, register file model on the
  system side, random bytes from an xorshift source.
  Assumes sirs_pkg, sirs_top and sirs_host are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // Signals and models
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic i2c_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cfg_lo = 2'h1; // Strap: 0 ground, 1 clock, 2 data, 3 supply
  logic [1:0] cfg_hi = 2'h2;
  logic scl;
  logic host_low;
  logic sda_o;
  logic sda_oe;
  logic reg_wr;
  logic [7:0] reg_ptr;
  logic [7:0] reg_wdata;
  logic [31:0] seed = 32'h00011987;
  logic [7:0] regs [256];
  logic [7:0] shadow [256];
  sirs_pkg::sirs_xfer_s wq [$];
  int err_count = 0;
  int n_compared = 0;
  wire logic sda;
  wire logic strap_lo;
  wire logic strap_hi;
  wire logic [7:0] reg_rdata;

  // Clocks, link clock offset in phase
  always #10 sys_clk = ~sys_clk;
  initial #7 forever #32 i2c_clk = ~i2c_clk;

  // Open-drain wire with pull-up; straps follow their chosen level
  assign sda = ((sda_oe && !sda_o) || host_low) ? 1'b0 : 1'b1;
  assign strap_lo = cfg_lo[1] ? (cfg_lo[0] | sda) : (cfg_lo[0] & scl);
  assign strap_hi = cfg_hi[1] ? (cfg_hi[0] | sda) : (cfg_hi[0] & scl);
  assign reg_rdata = regs[reg_ptr];

  sirs_host host (.clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

  sirs_top dut (
    .sys_clk_i(sys_clk),
    .rst_i(rst),
    .i2c_clk_i(i2c_clk),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe),
    .strap_pin_low_pair_i(strap_lo),
    .strap_pin_high_pair_i(strap_hi),
    .reg_ptr_o(reg_ptr),
    .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr),
    .reg_rdata_i(reg_rdata)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Prefix 100, then high and low strap pairs; strap code equals its pair
  function automatic logic [6:0] exp_addr(input logic [1:0] hi, input logic [1:0] lo);
    return {3'h4, hi, lo};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim;
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Register file stores writes mid-cycle, clear of the launching edge
  always @(negedge sys_clk) begin
    if (reg_wr === 1'b1) begin
      regs[reg_ptr] <= reg_wdata;
      if (wq.size() == 0) begin
        chk(8'h01, 8'h00, "stray write");
      end else begin
        chk(reg_ptr, wq[0].ptr, "write pointer");
        chk(reg_wdata, wq[0].data, "write data");
        wq.delete(0);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    end_sim;
  end

  // ------------------------------------------------------------
  // Bus transfers
  // ------------------------------------------------------------
  // Reset held across several link-clock edges, then settle time
  task automatic do_reset;
    rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    chk(reg_ptr, 8'h00, "reset pointer");
    chk({6'h0, reg_wr, sda_oe}, 8'h00, "reset outputs");
    rst = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask

  // Start, write-direction address, register byte
  task automatic head(input logic [6:0] a, input logic [7:0] r);
    logic ak;
    host.start;
    host.wbyte({a, 1'b0}, ak);
    chk({7'h0, ak}, 8'h01, "address ack");
    host.wbyte(r, ak);
    chk({7'h0, ak}, 8'h01, "register ack");
  endtask

  task automatic wr_xfer(input logic [6:0] a, input logic [7:0] r, input int n);
    logic ak;
    sirs_pkg::sirs_xfer_s e;
    head(a, r);
    for (int i = 0; i < n; i++) begin
      e.write = 1'b1;
      e.ptr = 8'(r + i);
      e.data = xs();
      shadow[e.ptr] = e.data;
      wq.push_back(e);
      host.wbyte(e.data, ak);
      chk({7'h0, ak}, 8'h01, "data ack");
    end
    host.stop;
  endtask

  // Optional register byte, repeated start, read n bytes, last one refused
  task automatic rd_xfer(input logic [6:0] a, input logic [7:0] r, input logic setreg,
                         input int n);
    logic ak;
    logic [7:0] d;
    if (setreg) begin
      head(a, r);
    end
    host.start;
    host.wbyte({a, 1'b1}, ak);
    chk({7'h0, ak}, 8'h01, "read address ack");
    for (int i = 0; i < n; i++) begin
      host.rbyte(i < n - 1, d);
      chk(d, shadow[8'(r + i)], "read data");
    end
    host.q;
    chk({7'h0, sda}, 8'h01, "release after no ack");
    host.stop;
  endtask

  // Foreign address: no acknowledge, host abandons
  task automatic nak_xfer(input logic [6:0] a);
    logic ak;
    host.start;
    host.wbyte({a, 1'b0}, ak);
    chk({7'h0, ak}, 8'h00, "foreign address ack");
    host.stop;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [6:0] a;
    logic [7:0] r;
    int n;
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'h5a;
      shadow[i] = regs[i];
    end
    do_reset;
    a = exp_addr(cfg_hi, cfg_lo);
    for (int k = 0; k < 2; k++) begin
      r = xs() & 8'h7f;
      n = 2 + int'(xs() & 8'h01);
      wr_xfer(a, r, n);
      rd_xfer(a, 8'(r + n), 1'b0, 1);
      rd_xfer(a, r, 1'b1, n);
    end
    nak_xfer(a ^ 7'h08);
    nak_xfer(a ^ 7'h40);
    r = xs() & 8'h7f;
    wr_xfer(a, r, 0);
    rd_xfer(a, r, 1'b0, 2);
    cfg_lo = 2'h3;
    cfg_hi = 2'h0;
    do_reset;
    rd_xfer(exp_addr(cfg_hi, cfg_lo), 8'h00, 1'b0, 1);
    nak_xfer(a);
    a = exp_addr(cfg_hi, cfg_lo);
    r = xs() & 8'h7f;
    wr_xfer(a, r, 2);
    rd_xfer(a, r, 1'b1, 2);
    chk(8'(wq.size()), 8'h00, "missing writes");
    chk({7'h0, sda_o}, 8'h00, "drive value");
    end_sim;
  end
endmodule
`default_nettype wire
